// ---- core/flash_host.sv ----
`timescale 1ns/10ps
`include "flash_host_defines.svh"
// What this block does
// - Reset, suspend and resume are single writes, address don't-care.
// - Unlock addresses 555/2AA word, AAA/555 byte incl. low byte bit.
// - Program: AA, 55, A0, then the value at its target address.
// - Erase: unlock, 80, unlock, then 10 chip or 30 at sector.
// - Pin protect verify carries the sector on address 19..12.
// - Read: select and output gate low, write strobe high.
module flash_host import flash_host_pkg::*; #(
	parameter int WP_CYCLES = `FL_WP_CYC,
	parameter int WPH_CYCLES = `FL_WPH_CYC,
	parameter int ACC_CYCLES = `FL_ACC_CYC,
	parameter int RP_CYCLES = `FL_RP_CYC
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Request and answer
	input wire logic req_valid,
	input wire req_t req,
	output logic req_ready,
	output rsp_t rsp,
	// Flash pins
	output pins_t pins,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe_b,
	input wire logic [15:0] dq_in
);
	localparam int READ_WAIT = ACC_CYCLES + `FL_SYNC_CYC;

	if (WP_CYCLES < 1 || WPH_CYCLES < 1 || RP_CYCLES < 1 ||
	    ACC_CYCLES < 1 || WP_CYCLES > 255 || WPH_CYCLES > 255 ||
	    RP_CYCLES > 255 || READ_WAIT > 255) begin : timing_check
		$error("flash_host: timing counts must lie in 1..255");
	end

	state_t state, next_state;
	logic [7:0] cnt, next_cnt;
	logic [2:0] idx, next_idx;
	req_t cur, next_cur;
	logic erase_active, next_erase_active;
	logic suspended, next_suspended;
	logic in_special, next_in_special;
	logic next_req_ready;
	rsp_t next_rsp;
	pins_t next_pins;
	logic [15:0] next_dq_out;
	logic [15:0] next_dq_oe_b;
	logic [15:0] dq_settled;
	step_t stp;

	flash_data_sync #(.WIDTH(16)) data_sync (
		.clock(clock),
		.rst_b(rst_b),
		.raw(dq_in),
		.settled(dq_settled)
	);

	function automatic logic [2:0] last_idx(input op_t op);
		unique case (op)
			op_ident: last_idx = 3'h2;
			op_program: last_idx = 3'h3;
			op_chip_erase, op_sector_erase: last_idx = 3'h5;
			default: last_idx = 3'h0;
		endcase
	endfunction

	function automatic logic refuse(input op_t op, input logic ea,
		input logic su, input logic sp);
		logic cmd_op;
		cmd_op = (op == op_program) || (op == op_chip_erase) ||
			(op == op_sector_erase) || (op == op_ident) || (op == op_query);
		// Suspend and resume refused outside a sector erase
		refuse = ((op == op_suspend) && (!ea || su)) ||
			((op == op_resume) && !su) || (sp && cmd_op);
	endfunction

	// One write cycle of a command sequence
	function automatic step_t cmd_step(input op_t op, input logic [2:0] i,
		input logic bm, input logic [20:0] ua, input logic [15:0] ud);
		step_t s;
		logic [20:0] u1;
		logic [20:0] u2;
		u1 = bm ? `FL_UNLOCK1_BYTE : `FL_UNLOCK1_WORD;
		u2 = bm ? `FL_UNLOCK2_BYTE : `FL_UNLOCK2_WORD;
		s.la = u1;
		s.data = {8'h00, `FL_CMD_UNLOCK1};
		if (i == 3'h1 || i == 3'h4) begin
			s.la = u2;
			s.data = {8'h00, `FL_CMD_UNLOCK2};
		end else if (i == 3'h2) begin
			s.data = {8'h00, (op == op_ident) ? `FL_CMD_IDENT :
				(op == op_program) ? `FL_CMD_PROGRAM : `FL_CMD_ERASE_SETUP};
		end else if (i == 3'h3 && op == op_program) begin
			s.la = ua;
			s.data = ud;
		end else if (i == 3'h5) begin
			s.la = (op == op_sector_erase) ? ua : u1;
			s.data = {8'h00, (op == op_sector_erase) ?
				`FL_CMD_SECTOR_ERASE : `FL_CMD_CHIP_ERASE};
		end else if (i == 3'h0) begin
			if (op == op_array_reset) begin
				s.la = '0;
				s.data = {8'h00, `FL_CMD_RESET};
			end else if (op == op_suspend) begin
				s.la = '0;
				s.data = {8'h00, `FL_CMD_SUSPEND};
			end else if (op == op_resume) begin
				s.la = '0;
				s.data = {8'h00, `FL_CMD_RESUME};
			end else if (op == op_query) begin
				s.data = {8'h00, `FL_CMD_QUERY};
			end
		end
		return s;
	endfunction

	// In byte mode bit 15 carries the low byte-address bit
	function automatic logic [19:0] pin_addr(input logic [20:0] la,
		input logic bm);
		pin_addr = bm ? la[20:1] : la[19:0];
	endfunction

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_idx = idx;
		next_cur = cur;
		next_erase_active = erase_active;
		next_suspended = suspended;
		next_in_special = in_special;
		next_req_ready = 1'b0;
		next_rsp = rsp;
		next_rsp.valid = 1'b0;
		next_pins = pins;
		next_dq_out = dq_out;
		next_dq_oe_b = dq_oe_b;
		stp = cmd_step(cur.op, idx, cur.byte_mode, cur.addr, cur.data);
		unique case (state)
			st_idle: begin
				next_req_ready = 1'b1;
				if (req_valid && req_ready) begin
					next_req_ready = 1'b0;
					next_cur = req;
					next_idx = 3'h0;
					if (refuse(req.op, erase_active, suspended, in_special)) begin
						next_state = st_answer;
						next_rsp = '{valid: 1'b1, refused: 1'b1, data: 16'h0000};
					end else if (req.op == op_hw_reset) begin
						next_state = st_hw_reset;
						next_cnt = 8'(RP_CYCLES);
						next_pins.reset_b = 1'b0;
						next_pins.ce_b = 1'b1;
					end else if (req.op == op_read ||
					             req.op == op_pin_verify) begin
						next_state = st_read;
						next_cnt = 8'(READ_WAIT);
						next_pins.ce_b = 1'b0;
						next_pins.oe_b = 1'b0;
						next_pins.we_b = 1'b1;
						next_pins.byte_b = !req.byte_mode;
						next_pins.addr = pin_addr(req.addr, req.byte_mode);
						next_dq_out = {req.addr[0], 15'h0000};
						next_dq_oe_b = req.byte_mode ? `FL_DQ_OE_BYTE_RD :
							`FL_DQ_OE_WORD_RD;
						if (req.op == op_pin_verify) begin
							next_pins.high_voltage_level = 1'b1;
							next_pins.addr = {req.addr[`FL_SECTOR_MSB:`FL_SECTOR_LSB],
								`FL_VERIFY_LOW};
						end
					end else begin
						next_state = st_setup;
					end
				end
			end
			st_setup: begin
				// Select low, gate high before the strobe
				next_pins.ce_b = 1'b0;
				next_pins.oe_b = 1'b1;
				next_pins.we_b = 1'b1;
				next_pins.byte_b = !cur.byte_mode;
				next_pins.addr = pin_addr(stp.la, cur.byte_mode);
				next_dq_out = cur.byte_mode ?
					{stp.la[0], 7'h00, stp.data[7:0]} : stp.data;
				next_dq_oe_b = cur.byte_mode ? `FL_DQ_OE_BYTE_WR :
					`FL_DQ_OE_WORD_WR;
				next_cnt = 8'(WP_CYCLES);
				next_state = st_strobe;
			end
			st_strobe: begin
				next_pins.we_b = (cnt == 8'h00);
				if (cnt == 8'h00) begin
					next_cnt = 8'(WPH_CYCLES);
					next_state = st_recover;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			st_recover: begin
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h01) begin
					if (idx == last_idx(cur.op)) begin
						next_state = st_answer;
						next_pins.ce_b = 1'b1;
						next_dq_oe_b = `FL_DQ_OE_WORD_RD;
						next_rsp = '{valid: 1'b1, refused: 1'b0, data: 16'h0000};
						// Mode kept until a reset write or a reset pin pulse
						if (cur.op == op_ident || cur.op == op_query) begin
							next_in_special = 1'b1;
						end else if (cur.op == op_array_reset) begin
							next_in_special = 1'b0;
							next_erase_active = 1'b0;
							next_suspended = 1'b0;
						end else if (cur.op == op_sector_erase) begin
							next_erase_active = 1'b1;
						end else if (cur.op == op_suspend) begin
							next_suspended = 1'b1;
						end else if (cur.op == op_resume) begin
							next_suspended = 1'b0;
						end
					end else begin
						next_idx = idx + 3'h1;
						next_state = st_setup;
					end
				end
			end
			st_read: begin
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h01) begin
					// Only the low byte counts in byte mode
					next_rsp = '{valid: 1'b1, refused: 1'b0, data: cur.byte_mode ?
						(dq_settled & `FL_BYTE_MASK) : dq_settled};
					next_pins.ce_b = 1'b1;
					next_pins.oe_b = 1'b1;
					next_pins.high_voltage_level = 1'b0;
					next_dq_oe_b = `FL_DQ_OE_WORD_RD;
					next_state = st_answer;
				end
			end
			st_hw_reset: begin
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h01) begin
					next_pins.reset_b = 1'b1;
					next_in_special = 1'b0;
					next_erase_active = 1'b0;
					next_suspended = 1'b0;
					next_rsp = '{valid: 1'b1, refused: 1'b0, data: 16'h0000};
					next_state = st_answer;
				end
			end
			st_answer: begin
				next_req_ready = 1'b1;
				next_state = st_idle;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= st_idle;
			cnt <= 8'h00;
			idx <= 3'h0;
			cur <= '0;
			erase_active <= 1'b0;
			suspended <= 1'b0;
			in_special <= 1'b0;
			req_ready <= 1'b0;
			rsp <= '0;
			pins <= '{reset_b: 1'b1, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1,
				byte_b: 1'b1, high_voltage_level: 1'b0, addr: 20'h00000};
			dq_out <= 16'h0000;
			dq_oe_b <= 16'hffff;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			idx <= next_idx;
			cur <= next_cur;
			erase_active <= next_erase_active;
			suspended <= next_suspended;
			in_special <= next_in_special;
			req_ready <= next_req_ready;
			rsp <= next_rsp;
			pins <= next_pins;
			dq_out <= next_dq_out;
			dq_oe_b <= next_dq_oe_b;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	write_gate_a: assert property (!pins.we_b |-> pins.oe_b && !pins.ce_b)
		else $error("write strobe low without select or with gate low");
	read_strobes_a: assert property ($rose(state == st_read) |->
		!pins.ce_b && !pins.oe_b && pins.we_b)
		else $error("read cycle without proper strobes");
	program_cmd_a: assert property (state == st_strobe && cur.op == op_program
		&& idx == 3'h2 |-> dq_out[7:0] == `FL_CMD_PROGRAM)
		else $error("program setup byte wrong");
	erase_final_a: assert property (state == st_strobe && idx == 3'h5 &&
		cur.op == op_chip_erase |-> dq_out[7:0] == `FL_CMD_CHIP_ERASE)
		else $error("chip erase final byte wrong");
	suspend_refused_a: assert property (req_valid && req_ready &&
		req.op == op_suspend && !erase_active |=> rsp.valid && rsp.refused)
		else $error("suspend accepted outside sector erase");
	single_write_a: assert property (state == st_recover && cnt == 8'h01 &&
		cur.op == op_array_reset |=> state == st_answer ##1 state == st_idle)
		else $error("reset command took more than one write");
	byte_unlock_a: assert property (state == st_strobe && cur.byte_mode &&
		idx == 3'h1 |-> pins.addr[10:0] == 11'h2aa && dq_out[15])
		else $error("byte mode second unlock address wrong");
	pin_verify_a: assert property (state == st_read &&
		cur.op == op_pin_verify |-> pins.high_voltage_level &&
		pins.addr[11:0] == `FL_VERIFY_LOW &&
		pins.addr[19:12] == cur.addr[19:12])
		else $error("pin protect verify address pattern wrong");
	hw_reset_a: assert property ($rose(state == st_hw_reset) |->
		!pins.reset_b && pins.ce_b ##1 !pins.reset_b)
		else $error("reset pin pulse malformed");
endmodule // flash_host

// ---- core/flash_host_defines.svh ----
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// Clock rate and bus timing, in MHz and ns
`define FL_CLK_MHZ 250
`define FL_WP_NS 35
`define FL_WPH_NS 30
`define FL_ACC_NS 90
`define FL_RP_NS 500
`define FL_CYC_MIN(ns) ((((ns) * `FL_CLK_MHZ) + 999) / 1000)
`define FL_WP_CYC `FL_CYC_MIN(`FL_WP_NS)
`define FL_WPH_CYC `FL_CYC_MIN(`FL_WPH_NS)
`define FL_ACC_CYC `FL_CYC_MIN(`FL_ACC_NS)
`define FL_RP_CYC `FL_CYC_MIN(`FL_RP_NS)
`define FL_SYNC_CYC 3

// Command data values
`define FL_CMD_UNLOCK1 8'haa
`define FL_CMD_UNLOCK2 8'h55
`define FL_CMD_IDENT 8'h90
`define FL_CMD_PROGRAM 8'ha0
`define FL_CMD_ERASE_SETUP 8'h80
`define FL_CMD_CHIP_ERASE 8'h10
`define FL_CMD_SECTOR_ERASE 8'h30
`define FL_CMD_RESUME 8'h30
`define FL_CMD_SUSPEND 8'hb0
`define FL_CMD_RESET 8'hf0
`define FL_CMD_QUERY 8'h98

// Unlock addresses, in word units or byte units
`define FL_UNLOCK1_WORD 21'h000555
`define FL_UNLOCK2_WORD 21'h0002aa
`define FL_UNLOCK1_BYTE 21'h000aaa
`define FL_UNLOCK2_BYTE 21'h000555

// Pin-driven protect check: sector field and low address pattern
`define FL_SECTOR_MSB 19
`define FL_SECTOR_LSB 12
`define FL_VERIFY_LOW 12'h002
`define FL_BYTE_MASK 16'h00ff
`define FL_DQ_OE_WORD_WR 16'h0000
`define FL_DQ_OE_BYTE_WR 16'h7f00
`define FL_DQ_OE_WORD_RD 16'hffff
`define FL_DQ_OE_BYTE_RD 16'h7fff

`endif

// ---- core/flash_host_pkg.sv ----
package flash_host_pkg;

	typedef enum logic [3:0] {
		op_read = 4'h0,
		op_array_reset = 4'h1,
		op_ident = 4'h2,
		op_query = 4'h3,
		op_program = 4'h4,
		op_chip_erase = 4'h5,
		op_sector_erase = 4'h6,
		op_suspend = 4'h7,
		op_resume = 4'h8,
		op_pin_verify = 4'h9,
		op_hw_reset = 4'ha
	} op_t;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_setup = 3'b001,
		st_strobe = 3'b010,
		st_recover = 3'b011,
		st_read = 3'b100,
		st_hw_reset = 3'b101,
		st_answer = 3'b110
	} state_t;

	typedef struct packed {
		op_t op;
		logic byte_mode;
		logic [20:0] addr;
		logic [15:0] data;
	} req_t;

	typedef struct packed {
		logic valid;
		logic refused;
		logic [15:0] data;
	} rsp_t;

	typedef struct packed {
		logic reset_b;
		logic ce_b;
		logic oe_b;
		logic we_b;
		logic byte_b;
		logic high_voltage_level;
		logic [19:0] addr;
	} pins_t;

	typedef struct packed {
		logic [20:0] la;
		logic [15:0] data;
	} step_t;

endpackage

// ---- core/flash_data_sync.sv ----
`timescale 1ns/10ps
`include "flash_host_defines.svh"
module flash_data_sync #(
	parameter int WIDTH = 16
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Raw pins and settled value
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] settled
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	wire logic [WIDTH-1:0] next_settled;

	if (WIDTH < 1) begin : width_check
		$error("flash_data_sync: WIDTH must be at least 1");
	end

	// A bit only moves once the second and third stages agree
	for (genvar i = 0; i < WIDTH; i++) begin : bit_g
		assign next_settled[i] = (s2[i] == s3[i]) ? s3[i] : settled[i];
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			settled <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			settled <= next_settled;
		end
	end
endmodule // flash_data_sync

// ---- test/flash_dev_model.sv ----
`timescale 1ns/10ps
module flash_dev_model import flash_host_pkg::*; #(
	parameter logic [15:0] MAKER = 16'h00a5,
	parameter logic [15:0] PART = 16'h22b7
)(
	// Clock for the float pattern
	input wire logic clock,
	// Pins from the host
	input wire pins_t pins,
	input wire logic [15:0] dq_out,
	input wire logic [15:0] dq_oe_b,
	// Resolved data lines
	output logic [15:0] dq_in
);
	logic [15:0] mem [int];
	logic [15:0] flt = 16'h5a5a;
	logic [15:0] q, dmask;
	logic [2:0] step = 3'h0;
	logic [1:0] mode = 2'h0;
	logic bm, drv;
	logic [7:0] wd;
	logic [11:0] ua, u1, u2;
	int wa;
	assign bm = !pins.byte_b;
	assign wd = dq_in[7:0];
	assign wa = int'(pins.addr);
	// Unlock address match
	// Byte unlock addresses span A10 down to A-1, twelve bits
	assign ua = bm ? {pins.addr[10:0], dq_in[15]} : {1'b0, pins.addr[10:0]};
	assign u1 = bm ? 12'haaa : 12'h555;
	assign u2 = bm ? 12'h555 : 12'h2aa;
	// Released lines change every cycle, never hold the last value
	always @(posedge clock) flt <= ~flt;
	assign drv = !pins.ce_b && !pins.oe_b && pins.we_b && pins.reset_b;
	assign dmask = drv ? (bm ? 16'h00ff : 16'hffff) : 16'h0000;
	assign dq_in = (~dq_oe_b & dq_out) | (dq_oe_b & dmask & q)
		| (dq_oe_b & ~dmask & flt);
	always @* begin
		if (pins.high_voltage_level)
			q = {15'h0, pins.addr[12]};
		else if (mode == 2'h1)
			q = (pins.addr[1:0] == 2'h2) ? {15'h0, pins.addr[12]} :
				(pins.addr[0] ? PART : MAKER);
		else if (mode == 2'h2)
			q = {8'h00, pins.addr[7:0] ^ 8'h3c};
		else
			q = mem.exists(wa) ? mem[wa] : 16'hffff;
		if (bm)
			q = dq_in[15] ? {8'h00, q[15:8]} : {8'h00, q[7:0]};
	end
	always @(posedge pins.we_b or negedge pins.reset_b) begin
		if (!pins.reset_b) begin
			step <= 3'h0;
			mode <= 2'h0;
		end else if (!pins.ce_b) begin
			step <= 3'h0;
			if (wd == 8'hf0)
				mode <= 2'h0;
			else case (step)
				3'h0: begin
					if (ua == u1 && wd == 8'haa) step <= 3'h1;
					else if (ua == u1 && wd == 8'h98) mode <= 2'h2;
				end
				3'h1: if (ua == u2 && wd == 8'h55) step <= 3'h2;
				3'h2: if (ua == u1 && wd == 8'h90) mode <= 2'h1;
					else if (ua == u1 && wd == 8'ha0) step <= 3'h3;
					else if (ua == u1 && wd == 8'h80) step <= 3'h4;
				// Word programming only; the bench never programs bytes
				3'h3: mem[wa] = (mem.exists(wa) ? mem[wa] : 16'hffff) & dq_in;
				3'h4: if (ua == u1 && wd == 8'haa) step <= 3'h5;
				3'h5: if (ua == u2 && wd == 8'h55) step <= 3'h6;
				3'h6: if (ua == u1 && wd == 8'h10) mem.delete();
					else if (wd == 8'h30) foreach (mem[k])
						if (k[19:12] == pins.addr[19:12]) mem[k] = 16'hffff;
				default: step <= 3'h0;
			endcase
		end
	end
endmodule // flash_dev_model

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top import flash_host_pkg::*;;
	localparam logic [15:0] MAKER_CODE = 16'h00a5;
	localparam logic [15:0] PART_CODE = 16'h22b7;
	logic clock = 0;
	logic rst_b = 0;
	logic req_valid = 0;
	req_t req = '0;
	logic req_ready;
	rsp_t rsp, r;
	pins_t pins;
	logic [15:0] dq_out, dq_oe_b, dq_in, v;
	logic [19:0] a, pa;
	int err_total = 0;
	int tests_run = 0;
	int seed = 32'h49f912fe;
	logic [15:0] shadow [int];
	always #2 clock = ~clock;
	// Short strobe and access counts keep the run brief
	flash_host #(.WP_CYCLES(2), .WPH_CYCLES(2), .ACC_CYCLES(4),
		.RP_CYCLES(5)) u_dut (.clock(clock), .rst_b(rst_b),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp(rsp), .pins(pins), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
		.dq_in(dq_in));
	flash_dev_model #(.MAKER(MAKER_CODE), .PART(PART_CODE)) u_dev (
		.clock(clock), .pins(pins), .dq_out(dq_out),
		.dq_oe_b(dq_oe_b), .dq_in(dq_in));
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Enters at 1 ns after an edge, leaves the same way
	task op(input op_t o, input logic b, input logic [20:0] ad,
		input logic [15:0] d);
		int n;
		n = 0;
		req_valid = 1;
		req = '{o, b, ad, d};
		while (req_ready !== 1'b1 && n < 300) begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
		#1;
		req_valid = 0;
		while (rsp.valid !== 1'b1 && n < 600) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 600) chk(16'h0, 16'h1, "no answer");
		r = rsp;
		@(posedge clock);
		#1;
	endtask
	function logic [15:0] exp_arr(input int w);
		return shadow.exists(w) ? shadow[w] : 16'hffff;
	endfunction
	function logic [15:0] exp_prot(input logic [19:0] w);
		return {15'h0, w[12]};
	endfunction
	task rd(input logic [19:0] w, input logic [15:0] e, input string m);
		op(op_read, 1'b0, {1'b0, w}, 16'h0);
		chk(r.data, e, m);
	endtask
	task refusal(input op_t o, input logic e, input string m);
		op(o, 1'b0, {1'b0, a}, 16'h0);
		chk({15'h0, r.refused}, {15'h0, e}, m);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#1;
		rst_b = 1;
		a = $random(seed);
		rd(a, 16'hffff, "blank read");
		for (int i = 0; i < 6; i++) begin
			// Odd passes reprogram the same word, so bits only clear
			if (i % 2 == 0) a = $random(seed);
			v = $random(seed);
			op(op_program, 1'b0, {1'b0, a}, v);
			shadow[int'(a)] = exp_arr(int'(a)) & v;
			rd(a, exp_arr(int'(a)), "program readback");
		end
		pa = a;
		$display("program test done");
		op(op_ident, 1'b0, 21'h0, 16'h0);
		a = $random(seed);
		rd({a[19:2], 2'b00}, MAKER_CODE, "maker code");
		rd({a[19:2], 2'b01}, PART_CODE, "part code");
		rd({a[19:2], 2'b10}, exp_prot(a), "protect verify");
		refusal(op_program, 1'b1, "program in ident");
		op(op_array_reset, 1'b0, 21'h0, 16'h0);
		rd(pa, exp_arr(int'(pa)), "read after reset");
		$display("ident test done");
		op(op_query, 1'b0, 21'h0, 16'h0);
		repeat (2) begin
			a = $random(seed);
			rd(a, {8'h00, a[7:0] ^ 8'h3c}, "query read");
		end
		op(op_array_reset, 1'b0, 21'h0, 16'h0);
		$display("query test done");
		refusal(op_suspend, 1'b1, "suspend idle");
		refusal(op_resume, 1'b1, "resume idle");
		op(op_sector_erase, 1'b0, {1'b0, pa}, 16'h0);
		foreach (shadow[k])
			if (k[19:12] == pa[19:12]) shadow[k] = 16'hffff;
		refusal(op_suspend, 1'b0, "suspend erase");
		refusal(op_resume, 1'b0, "resume erase");
		rd(pa, 16'hffff, "sector erased");
		op(op_array_reset, 1'b0, 21'h0, 16'h0);
		a = $random(seed);
		v = $random(seed);
		op(op_program, 1'b0, {1'b0, a}, v);
		op(op_chip_erase, 1'b0, 21'h0, 16'h0);
		shadow.delete();
		rd(a, 16'hffff, "chip erased");
		$display("erase test done");
		for (int i = 0; i < 2; i++) begin
			a = $random(seed);
			a[12] = i[0];
			op(op_pin_verify, 1'b0, {1'b0, a}, 16'h0);
			chk({8'h00, r.data[7:0]}, exp_prot(a), "pin verify");
		end
		$display("pin verify test done");
		a = $random(seed);
		v = $random(seed);
		op(op_program, 1'b0, {1'b0, a}, v);
		op(op_read, 1'b1, {a, 1'b0}, 16'h0);
		chk(r.data, {8'h00, v[7:0]}, "byte low");
		op(op_read, 1'b1, {a, 1'b1}, 16'h0);
		chk(r.data, {8'h00, v[15:8]}, "byte high");
		op(op_ident, 1'b1, 21'h0, 16'h0);
		op(op_read, 1'b1, 21'h0, 16'h0);
		chk(r.data, {8'h00, MAKER_CODE[7:0]}, "byte ident");
		op(op_hw_reset, 1'b0, 21'h0, 16'h0);
		rd(a, v, "read after pin reset");
		$display("byte and reset test done");
		end_sim;
	end
	initial begin
		#100000;
		err_total++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		end_sim;
	end
endmodule // tb_top
